// >>> rtl/txtr_consts.svh
// Purpose: Offsets, field positions, reset values and limits of the
//          transmit translation table.
// Assumes: Byte-wide registers on a plain address port.
// Notes:   Definitions only.
`ifndef TXTR_CONSTS_SVH
`define TXTR_CONSTS_SVH

// ---------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------
`define TXTR_ADDR_W        11
`define TXTR_OFS_INDEX     11'h41b
`define TXTR_OFS_DATA      11'h41c

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define TXTR_DIR_BIT       7
`define TXTR_ACTIVE_BIT    7

// ---------------------------------------------------------------------
// Codes and reset values
// ---------------------------------------------------------------------
`define TXTR_GROUP_BASE    6'h20
`define TXTR_GROUP_LAST    6'h2f
`define TXTR_UNASSIGNED    6'h30
`define TXTR_NUM_ADDR      32
`define TXTR_NUM_CHAN      48
`define TXTR_INDEX_RST     8'h00
`define TXTR_DEFAULT_PORTS 32
`define TXTR_DEFAULT_GRPS  16

`endif

// >>> rtl/txtr_pkg.sv
// Purpose: Types shared by the translation table modules.
// Assumes: Nothing beyond the constants header.
// Notes:   Types only.
package txtr_pkg;

	typedef logic [5:0] txtr_chan_t;
	typedef logic [4:0] txtr_addr_t;

	typedef enum logic [1:0] {
		TXTR_KIND_PORT  = 2'b00,
		TXTR_KIND_GROUP = 2'b01,
		TXTR_KIND_NONE  = 2'b10,
		TXTR_KIND_BAD   = 2'b11
	} txtr_kind_e;

endpackage

// >>> rtl/txtr_lookup_if.sv
// Purpose: Lookup path between the table and its code decoder.
// Assumes: Single clock domain.
// Notes:   Combinational carrier only.
`timescale 1ns/1ns
interface txtr_lookup_if;
	txtr_pkg::txtr_chan_t code;
	txtr_pkg::txtr_kind_e kind;
	logic [4:0]           number;
	modport table_end (output code, input kind, input number);
	modport decoder_end (input code, output kind, output number);
endinterface

// >>> rtl/txtr_chan_decode.sv
// Purpose: Classifies an internal channel code as port, group or none.
// Assumes: Ports and groups counts set by the smaller variants.
// Notes:   Codes past the variant's range come out as illegal.
`timescale 1ns/1ns
`include "txtr_consts.svh"
module txtr_chan_decode #(
	parameter int NUM_PORTS  = `TXTR_DEFAULT_PORTS,
	parameter int NUM_GROUPS = `TXTR_DEFAULT_GRPS
) (
	txtr_lookup_if.decoder_end lk
);

	// ---------------------------------------------------------------
	// Code classification
	// ---------------------------------------------------------------
	always_comb begin
		lk.kind   = txtr_pkg::TXTR_KIND_BAD;
		lk.number = 5'h00;
		if (lk.code < 6'(NUM_PORTS)) begin
			lk.kind   = txtr_pkg::TXTR_KIND_PORT;
			lk.number = lk.code[4:0];
		end else if (lk.code >= `TXTR_GROUP_BASE &&
			lk.code < 6'(`TXTR_GROUP_BASE + NUM_GROUPS)) begin
			lk.kind   = txtr_pkg::TXTR_KIND_GROUP;
			lk.number = 5'(lk.code - `TXTR_GROUP_BASE);
		end else if (lk.code == `TXTR_UNASSIGNED) begin
			lk.kind = txtr_pkg::TXTR_KIND_NONE;
		end
	end

endmodule // txtr_chan_decode

// >>> rtl/txtr_table.sv
// Purpose: Transmit translation table behind an indirect register pair.
// Assumes: Single 10 MHz clock, synchronous active-high reset; the
//          register master never needs to be held off.
// Notes:   Read data valid the cycle after the read strobe only.
//          Route and reverse lookups answer one cycle after sampling.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "txtr_consts.svh"
module txtr_table #(
	parameter int NUM_PORTS  = `TXTR_DEFAULT_PORTS,
	parameter int NUM_GROUPS = `TXTR_DEFAULT_GRPS
) (
	input  wire logic                     clock,
	input  wire logic                     srst,
	input  wire logic [`TXTR_ADDR_W-1:0]  reg_addr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [7:0]               reg_rdata,
	input  wire logic                     route_req,
	input  wire logic [4:0]               route_addr,
	output logic                          route_valid,
	output txtr_pkg::txtr_kind_e          route_kind,
	output logic      [4:0]               route_number,
	input  wire logic [5:0]               rev_chan,
	output logic                          rev_active,
	output logic      [4:0]               rev_addr
);

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic [7:0]           index;
	txtr_pkg::txtr_chan_t fwd_map [`TXTR_NUM_ADDR];
	txtr_pkg::txtr_addr_t rev_map [`TXTR_NUM_CHAN];
	logic                 rev_on  [`TXTR_NUM_CHAN];
	logic                 dir;
	txtr_pkg::txtr_addr_t sel_addr;
	txtr_pkg::txtr_chan_t sel_chan;
	logic                 wr_index;
	logic                 wr_data;
	logic                 wr_fwd;
	logic                 wr_rev;
	logic                 rd_index;
	logic                 rd_data;
	logic                 chan_ok;
	logic                 rev_ok;
	logic [7:0]           next_rdata;
	logic                 next_rev_active;
	txtr_pkg::txtr_addr_t next_rev_addr;
	txtr_lookup_if        lk ();

	// ---------------------------------------------------------------
	// Channel code decoder
	// ---------------------------------------------------------------
	txtr_chan_decode #(
		.NUM_PORTS  (NUM_PORTS),
		.NUM_GROUPS (NUM_GROUPS)
	) u_decode (
		.lk (lk)
	);

	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------
	// Address match against one register offset.
	function automatic logic reg_hit(
		input logic [`TXTR_ADDR_W-1:0] addr,
		input logic [`TXTR_ADDR_W-1:0] ofs
	);
		return addr == ofs;
	endfunction

	// Reverse entries exist only for the channel codes of the table.
	function automatic logic chan_in_table(
		input txtr_pkg::txtr_chan_t code
	);
		return code < 6'(`TXTR_NUM_CHAN);
	endfunction

	// Forward entry as seen through the data register.
	function automatic logic [7:0] fwd_word(
		input txtr_pkg::txtr_chan_t code
	);
		return {2'b00, code};
	endfunction

	// Reverse entry as seen through the data register.
	function automatic logic [7:0] rev_word(
		input logic                 on,
		input txtr_pkg::txtr_addr_t addr
	);
		return {on, 2'b00, addr};
	endfunction

	// ---------------------------------------------------------------
	// Access decode
	// ---------------------------------------------------------------
	// direction from index bit 7
	assign dir      = index[`TXTR_DIR_BIT];
	assign sel_addr = index[4:0];
	assign sel_chan = index[5:0];
	assign wr_index = reg_wr && reg_hit(reg_addr, `TXTR_OFS_INDEX);
	assign wr_data  = reg_wr && reg_hit(reg_addr, `TXTR_OFS_DATA);
	assign rd_index = reg_rd && reg_hit(reg_addr, `TXTR_OFS_INDEX);
	assign rd_data  = reg_rd && reg_hit(reg_addr, `TXTR_OFS_DATA);
	// Channels beyond the table are dropped rather than aliased.
	assign chan_ok  = chan_in_table(sel_chan);
	assign rev_ok   = chan_in_table(rev_chan);
	// data write goes to one table by direction
	assign wr_fwd   = wr_data && !dir;
	assign wr_rev   = wr_data && dir && chan_ok;

	// ---------------------------------------------------------------
	// Index register
	// ---------------------------------------------------------------
	// index selects the entry
	always_ff @(posedge clock) begin
		if (srst) begin
			index <= `TXTR_INDEX_RST;
		end else if (wr_index) begin
			index <= reg_wdata;
		end
	end

	// ---------------------------------------------------------------
	// Forward table
	// ---------------------------------------------------------------
	// only the selected entry changes
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < `TXTR_NUM_ADDR; i++) begin
				fwd_map[i] <= `TXTR_UNASSIGNED;
			end
		end else if (wr_fwd) begin
			fwd_map[sel_addr] <= reg_wdata[5:0];
		end
	end

	// ---------------------------------------------------------------
	// Reverse table
	// ---------------------------------------------------------------
	// only the selected channel changes
	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < `TXTR_NUM_CHAN; i++) begin
				rev_map[i] <= 5'h00;
			end
		end else if (wr_rev) begin
			rev_map[sel_chan] <= reg_wdata[4:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			for (int i = 0; i < `TXTR_NUM_CHAN; i++) begin
				rev_on[i] <= 1'b0;
			end
		end else if (wr_rev) begin
			rev_on[sel_chan] <= reg_wdata[`TXTR_ACTIVE_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Read-back
	// ---------------------------------------------------------------
	// data word by direction
	always_comb begin
		next_rdata = 8'h00;
		if (rd_index) begin
			next_rdata = index;
		end else if (rd_data && !dir) begin
			next_rdata = fwd_word(fwd_map[sel_addr]);
		end else if (rd_data && chan_ok) begin
			next_rdata = rev_word(rev_on[sel_chan],
				rev_map[sel_chan]);
		end
	end

	// Read data stand one cycle and are zero otherwise, so a stale
	// value never looks like a fresh answer.
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// ---------------------------------------------------------------
	// Routing lookups
	// ---------------------------------------------------------------
	// transmit path consults the forward map
	assign lk.code = fwd_map[route_addr];

	// request marker travels with its answer
	always_ff @(posedge clock) begin
		if (srst) begin
			route_valid <= 1'b0;
		end else begin
			route_valid <= route_req;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			route_kind   <= txtr_pkg::TXTR_KIND_NONE;
			route_number <= 5'h00;
		end else begin
			route_kind   <= lk.kind;
			route_number <= lk.number;
		end
	end

	// ---------------------------------------------------------------
	// Reverse lookup
	// ---------------------------------------------------------------
	// codes past the table read as an idle channel
	always_comb begin
		next_rev_active = 1'b0;
		next_rev_addr   = 5'h00;
		if (rev_ok) begin
			next_rev_active = rev_on[rev_chan];
			next_rev_addr   = rev_map[rev_chan];
		end
	end

	// reverse map for outgoing cell addresses
	always_ff @(posedge clock) begin
		if (srst) begin
			rev_active <= 1'b0;
			rev_addr   <= 5'h00;
		end else begin
			rev_active <= next_rev_active;
			rev_addr   <= next_rev_addr;
		end
	end

endmodule // txtr_table

// >>> tb/txtr_table_chk.sv
// Purpose: Port assertions for the transmit translation table.
// Assumes: One clock, srst synchronous and active high.
// Notes:   Bound to every txtr_table instance.
`timescale 1ns/1ns
`include "txtr_consts.svh"
module txtr_table_chk (
	input wire logic                    clock,
	input wire logic                    srst,
	input wire logic [`TXTR_ADDR_W-1:0] reg_addr,
	input wire logic [7:0]              reg_wdata,
	input wire logic                    reg_wr,
	input wire logic                    reg_rd,
	input wire logic [7:0]              reg_rdata,
	input wire logic                    route_req,
	input wire logic                    route_valid,
	input wire txtr_pkg::txtr_kind_e    route_kind,
	input wire logic [5:0]              rev_chan,
	input wire logic                    rev_active,
	input wire logic [4:0]              rev_addr
);
	// ----
	// Checks
	// ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	logic [7:0] idx;
	logic       wi, wd, ri, rdd;
	assign wi = reg_wr && reg_addr == `TXTR_OFS_INDEX;
	assign wd = reg_wr && reg_addr == `TXTR_OFS_DATA;
	assign ri = reg_rd && reg_addr == `TXTR_OFS_INDEX;
	assign rdd = reg_rd && reg_addr == `TXTR_OFS_DATA;
	// The shadow index lets the data checks know the direction in force.
	always_ff @(posedge clock) begin
		if (srst) idx <= `TXTR_INDEX_RST;
		else if (wi) idx <= reg_wdata;
	end
	a_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_unmapped_zero: assert property (reg_rd && !ri && !rdd |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	a_index_echo: assert property (wi ##1 ri |=>
		reg_rdata == $past(reg_wdata, 2)) else $error("index readback");
	a_dir0_echo: assert property (wd && !idx[7] ##1 rdd |=>
		reg_rdata == {2'b00, $past(reg_wdata[5:0], 2)})
		else $error("forward entry readback");
	a_dir1_echo: assert property (wd && idx[7] && idx[5:0] < 6'h30 ##1
		rdd |=> reg_rdata == {$past(reg_wdata[7], 2), 2'b00,
		$past(reg_wdata[4:0], 2)}) else $error("reverse entry readback");
	a_data_bits: assert property (rdd |=> !reg_rdata[6])
		else $error("ignored data bit read as one");
	a_route_delay: assert property (route_valid == $past(route_req))
		else $error("route valid not one cycle after request");
	a_rev_range: assert property (rev_chan >= 6'h30 |=>
		!rev_active && rev_addr == 5'h00) else $error("reverse out of range");
	cover property (wd && idx[7]);
	cover property (route_valid && route_kind == txtr_pkg::TXTR_KIND_GROUP);
	cover property (wi ##1 ri);
	cover property (route_valid && route_kind == txtr_pkg::TXTR_KIND_BAD);
endmodule // txtr_table_chk
bind txtr_table txtr_table_chk txtr_table_chk_inst (.clock, .srst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .route_req, .route_valid,
	.route_kind, .rev_chan, .rev_active, .rev_addr);

// >>> tb/tx_utopia_channel_translation_tb_top.sv
// Purpose: Directed register and lookup tests of the translation table.
// Assumes: Default variant with 32 ports and 16 groups.
// Notes:   Expected values follow from the code ranges alone.
`timescale 1ns/1ns
`include "txtr_consts.svh"
module tx_utopia_channel_translation_tb_top;
	localparam logic [10:0] ix = `TXTR_OFS_INDEX;
	localparam logic [10:0] dt = `TXTR_OFS_DATA;
	logic       clock = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic       route_req = 1'b0, route_valid, rev_active;
	logic [10:0] reg_addr = 11'h000;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, ek, en;
	logic [4:0] route_addr = 5'h00, route_number, rev_addr;
	logic [5:0] rev_chan = 6'h00;
	logic [5:0] codes [5] = '{6'h00, 6'h1f, 6'h20, 6'h2f, 6'h30};
	txtr_pkg::txtr_kind_e route_kind;
	int         n_fail = 0, check_count = 0, k;
	always #50 clock = ~clock;
	txtr_table txtr_table_inst (.clock, .srst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .route_req, .route_addr, .route_valid, .route_kind,
		.route_number, .rev_chan, .rev_active, .rev_addr);
	task automatic chk(input string w, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask
	// A read, lookup or reset lowers a write strobe, so accesses run back to back.
	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	task automatic rd(input logic [10:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask
	task automatic look(input logic [4:0] a, input logic [5:0] c,
		input logic [7:0] k, n, ac, ad);
		@(posedge clock);
		reg_wr <= 1'b0;
		route_req <= 1'b1;
		route_addr <= a;
		rev_chan <= c;
		@(posedge clock);
		route_req <= 1'b0;
		#1 chk("route_valid", 8'h01, {7'h0, route_valid});
		chk("route_kind", k, {6'h0, route_kind});
		chk("route_number", n, {3'h0, route_number});
		chk("rev_active", ac, {7'h0, rev_active});
		chk("rev_addr", ad, {3'h0, rev_addr});
	endtask
	// A reset in mid-run must bring back the power-up table.
	task automatic pulse_reset;
		@(posedge clock);
		reg_wr <= 1'b0;
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		#1 chk("route_kind", 8'h02, {6'h0, route_kind});
		chk("route_valid", 8'h00, {7'h0, route_valid});
		@(posedge clock);
		srst <= 1'b0;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ----
	// Tests
	// ----
	initial begin
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		rd(ix, 8'h00);
		rd(dt, 8'h30);
		look(5'h00, 6'h00, 8'h02, 8'h00, 8'h00, 8'h00);
		for (k = 0; k < 5; k++) begin
			wr(ix, 8'(k * 7));
			wr(dt, {2'b11, codes[k]});
			rd(dt, {2'b00, codes[k]});
		end
		for (k = 0; k < 5; k++) begin
			ek = codes[k] < 6'h20 ? 8'h00 : codes[k] < 6'h30 ? 8'h01 : 8'h02;
			en = codes[k] < 6'h20 ? 8'(codes[k]) :
				codes[k] < 6'h30 ? 8'(codes[k] - 6'h20) : 8'h00;
			wr(ix, 8'(k * 7));
			rd(dt, {2'b00, codes[k]});
			look(5'(k * 7), 6'h30 + 6'(k), ek, en, 8'h00, 8'h00);
		end
		wr(ix, 8'hc5);
		rd(ix, 8'hc5);
		wr(dt, 8'h6a);
		rd(dt, 8'h0a);
		wr(ix, 8'haf);
		wr(dt, 8'hff);
		rd(dt, 8'h9f);
		look(5'h00, 6'h2f, 8'h00, 8'h00, 8'h01, 8'h1f);
		look(5'h07, 6'h05, 8'h00, 8'h1f, 8'h00, 8'h0a);
		wr(ix, 8'hb0);
		wr(dt, 8'h81);
		rd(dt, 8'h00);
		wr(11'h41d, 8'h55);
		rd(11'h41d, 8'h00);
		rd(ix, 8'hb0);
		wr(ix, 8'h03);
		wr(dt, 8'h3f);
		rd(dt, 8'h3f);
		look(5'h03, 6'h00, 8'h03, 8'h00, 8'h00, 8'h00);
		pulse_reset();
		rd(ix, 8'h00);
		rd(dt, 8'h30);
		look(5'h07, 6'h2f, 8'h02, 8'h00, 8'h00, 8'h00);
		stop_test();
	end
	initial begin
		#100000;
		n_fail++;
		stop_test();
	end
endmodule // tx_utopia_channel_translation_tb_top
